// ### shared/power_down_pkg.sv
// Constants, types and state record of the power-down controller
package power_down_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on haddr[7:0])
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	localparam int KEY_LSB = 24;
	localparam int KEY_MSB = 31;
	localparam logic [7:0] WRITE_PASSWORD_VALUE = 8'hA5;
	localparam int REQ_BIT = 0;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int CPT_LSB = 4;
	localparam int CPT_MSB = 7;
	localparam int ALARM_EN_BIT = 17;
	localparam int IN_FLAG_BIT = 0;
	localparam int ALARM_FLAG_BIT = 17;
	localparam int IRQ_IN_BIT = 0;
	localparam int IRQ_ALARM_BIT = 1;
	localparam logic [31:0] CFG_RESET = 32'h0000_0003;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int DEB_W = 8;
	localparam int DEB_SHIFT = 4;
	localparam logic [DEB_W-1:0] DEB_ADD = 8'h01;
	localparam int SD_DELAY = 2;

	// ----------------------------------------------------------------
	// Bus encodings and types
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		MODE_NONE = 2'b00,
		MODE_RISE = 2'b01,
		MODE_FALL = 2'b10,
		MODE_ANY = 2'b11
	} edge_mode_type;

	typedef struct packed {
		logic power_off;
		logic irq;
		logic hreadyout;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		edge_mode_type cfg_mode;
		logic [3:0] cfg_cpt;
		logic cfg_alarm_en;
		logic in_flag;
		logic alarm_flag;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [SD_DELAY-1:0] sd_pipe;
		logic wake_prev;
		logic armed;
		logic level;
		logic [DEB_W-1:0] deb_cnt;
		logic alarm_s1;
		logic alarm_s2;
		logic alarm_s3;
	} ctrl_state_type;

endpackage : power_down_pkg

// ### src/power_down_controller.sv
// Power-down controller: password shutdown, debounced wake, alarm wake
//
// Function
// - Keyed write with request bit asserts output
// - Wrong key discards whole command write
// - Edge mode: none, rising, falling, any
// - Release after level held cpt*16+1 cycles
// - Enabled alarm releases output; disabled ignored
// - Input wake flag bit0, cleared by read
// - Alarm wake flag bit17, cleared by read
// - Shutdown takes effect two cycles after write
// - Input change during debounce clears counter, or restarts it at one in any-edge mode
// - Alarm rising edge synchronized before use
// - Block runs continuously on its clock
`timescale 1ns/100ps

module power_down_controller (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wake_input,
	input wire logic rtc_alarm,
	output logic power_off_output,
	output logic irq
);
	import power_down_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam int DEB_MAX = (15 << DEB_SHIFT) + 1;

	if (DEB_MAX >= (1 << DEB_W)) begin : g_bad_width
		$error("Debounce counter too narrow");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ctrl_state_type q;
	ctrl_state_type d;

	logic addr_ok;
	logic rd_req;
	logic rd_stat;
	logic wr_cmd;
	logic wr_cfg;
	logic wr_istat;
	logic wr_imask;
	logic cmd_ok;
	logic trig;
	logic wake_evt;
	logic alarm_rise;
	logic alarm_evt;
	logic release_evt;
	logic [DEB_W-1:0] tgt;
	logic [DEB_W-1:0] cnt_next;
	logic [31:0] rd_mux;
	logic [1:0] istat_next;

	assign hreadyout = q.hreadyout;
	assign hresp = HRESP_OKAY;
	assign hrdata = q.hrdata;
	assign power_off_output = q.power_off;
	assign irq = q.irq;

	always_comb begin
		d = q;

		// ------------------------------------------------------------
		// Bus address and data phases
		// ------------------------------------------------------------
		// Zero wait states; size is not checked, whole words assumed
		addr_ok = hsel && (htrans == HTRANS_NONSEQ) && hready;
		rd_req = addr_ok && !hwrite;
		rd_stat = rd_req && (haddr[ADDR_W-1:0] == OFS_STAT);
		d.hreadyout = 1'b1;
		d.wr_pend = addr_ok && hwrite;
		d.wr_addr = haddr[ADDR_W-1:0];

		wr_cmd = q.wr_pend && (q.wr_addr == OFS_CMD);
		wr_cfg = q.wr_pend && (q.wr_addr == OFS_CFG);
		wr_istat = q.wr_pend && (q.wr_addr == OFS_IRQ_STAT);
		wr_imask = q.wr_pend && (q.wr_addr == OFS_IRQ_MASK);

		// ------------------------------------------------------------
		// Shutdown command
		// ------------------------------------------------------------
		// A wrong key drops the write whatever the request bit holds
		cmd_ok = wr_cmd && hwdata[REQ_BIT]
			&& (hwdata[KEY_MSB:KEY_LSB] == WRITE_PASSWORD_VALUE);
		d.sd_pipe = {q.sd_pipe[SD_DELAY-2:0], cmd_ok};

		// ------------------------------------------------------------
		// Configuration
		// ------------------------------------------------------------
		if (wr_cfg) begin
			d.cfg_mode = edge_mode_type'(hwdata[MODE_MSB:MODE_LSB]);
			d.cfg_cpt = hwdata[CPT_MSB:CPT_LSB];
			d.cfg_alarm_en = hwdata[ALARM_EN_BIT];
		end
		if (wr_imask) begin
			d.irq_mask = {hwdata[IRQ_ALARM_BIT], hwdata[IRQ_IN_BIT]};
		end

		// ------------------------------------------------------------
		// Wake input edge detection and debounce
		// ------------------------------------------------------------
		d.wake_prev = wake_input;
		case (q.cfg_mode)
			MODE_NONE: trig = 1'b0;
			MODE_RISE: trig = wake_input && !q.wake_prev;
			MODE_FALL: trig = !wake_input && q.wake_prev;
			MODE_ANY: trig = wake_input != q.wake_prev;
			default: trig = 1'b0;
		endcase

		tgt = (DEB_W'(q.cfg_cpt) << DEB_SHIFT) + DEB_ADD;
		cnt_next = q.deb_cnt + DEB_ADD;
		wake_evt = 1'b0;
		if (trig) begin
			// The edge cycle itself is the first cycle at the new level
			d.level = wake_input;
			if (tgt == DEB_ADD) begin
				wake_evt = 1'b1;
				d.armed = 1'b0;
				d.deb_cnt = '0;
			end else begin
				d.armed = 1'b1;
				d.deb_cnt = DEB_ADD;
			end
		end else if (q.armed && (q.cfg_mode == MODE_NONE)) begin
			d.armed = 1'b0;
			d.deb_cnt = '0;
		end else if (q.armed) begin
			if (wake_input != q.level) begin
				d.armed = 1'b0;
				d.deb_cnt = '0;
			// At or past target, so a count shortened mid-run still ends
			end else if (cnt_next >= tgt) begin
				wake_evt = 1'b1;
				d.armed = 1'b0;
				d.deb_cnt = '0;
			end else begin
				d.deb_cnt = cnt_next;
			end
		end

		// ------------------------------------------------------------
		// Alarm synchronizer and edge
		// ------------------------------------------------------------
		// First stage feeds only the second; edge is taken later
		d.alarm_s1 = rtc_alarm;
		d.alarm_s2 = q.alarm_s1;
		d.alarm_s3 = q.alarm_s2;
		alarm_rise = q.alarm_s2 && !q.alarm_s3;
		alarm_evt = alarm_rise && q.cfg_alarm_en;

		// ------------------------------------------------------------
		// Output control
		// ------------------------------------------------------------
		// A wake in the same cycle as the delayed command wins
		release_evt = wake_evt || alarm_evt;
		if (release_evt) begin
			d.power_off = 1'b0;
		end else if (q.sd_pipe[SD_DELAY-1]) begin
			d.power_off = 1'b1;
		end else begin
			d.power_off = q.power_off;
		end

		// ------------------------------------------------------------
		// Status flags: an event in the read cycle survives the read
		// ------------------------------------------------------------
		d.in_flag = (q.in_flag && !rd_stat) || wake_evt;
		d.alarm_flag = (q.alarm_flag && !rd_stat) || alarm_evt;

		istat_next = q.irq_stat;
		if (wr_istat) begin
			istat_next = q.irq_stat
				& ~{hwdata[IRQ_ALARM_BIT], hwdata[IRQ_IN_BIT]};
		end
		istat_next = istat_next | {alarm_evt, wake_evt};
		d.irq_stat = istat_next;
		d.irq = |(istat_next & d.irq_mask);

		// ------------------------------------------------------------
		// Read data, captured at the address phase
		// ------------------------------------------------------------
		rd_mux = '0;
		case (haddr[ADDR_W-1:0])
			OFS_CFG: begin
				rd_mux[MODE_MSB:MODE_LSB] = q.cfg_mode;
				rd_mux[CPT_MSB:CPT_LSB] = q.cfg_cpt;
				rd_mux[ALARM_EN_BIT] = q.cfg_alarm_en;
			end
			OFS_STAT: begin
				rd_mux[IN_FLAG_BIT] = q.in_flag;
				rd_mux[ALARM_FLAG_BIT] = q.alarm_flag;
			end
			OFS_IRQ_STAT: begin
				rd_mux[IRQ_IN_BIT] = q.irq_stat[IRQ_IN_BIT];
				rd_mux[IRQ_ALARM_BIT] = q.irq_stat[IRQ_ALARM_BIT];
			end
			OFS_IRQ_MASK: begin
				rd_mux[IRQ_IN_BIT] = q.irq_mask[IRQ_IN_BIT];
				rd_mux[IRQ_ALARM_BIT] = q.irq_mask[IRQ_ALARM_BIT];
			end
			default: rd_mux = '0;
		endcase
		d.hrdata = rd_req ? rd_mux : '0;
	end

	// ----------------------------------------------------------------
	// Single state register, never gated
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.hreadyout <= 1'b1;
			q.cfg_mode <= edge_mode_type'(CFG_RESET[MODE_MSB:MODE_LSB]);
			q.cfg_cpt <= CFG_RESET[CPT_MSB:CPT_LSB];
			q.cfg_alarm_en <= CFG_RESET[ALARM_EN_BIT];
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_cmd_delay;
		cmd_ok ##1 !release_evt ##1 !release_evt |=> power_off_output;
	endproperty
	a_cmd_delay: assert property (p_cmd_delay)
		else $error("Shutdown not seen two cycles after command");

	property p_rise_cause;
		$rose(power_off_output) |-> $past(cmd_ok, 3);
	endproperty
	a_rise_cause: assert property (p_rise_cause)
		else $error("Output asserted without a keyed command");

	property p_bad_key;
		wr_cmd && (hwdata[KEY_MSB:KEY_LSB] != WRITE_PASSWORD_VALUE)
			|=> !q.sd_pipe[0];
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("Command with wrong key was accepted");

	property p_fall_mode;
		(q.cfg_mode == MODE_FALL) && $fell(wake_input)
			|=> q.armed || q.in_flag;
	endproperty
	a_fall_mode: assert property (p_fall_mode)
		else $error("Falling edge not detected in falling mode");

	property p_none_mode;
		(q.cfg_mode == MODE_NONE) && !wr_cfg |=> !q.armed && !wake_evt;
	endproperty
	a_none_mode: assert property (p_none_mode)
		else $error("Detection active while disabled");

	property p_debounce_len;
		wake_evt && !trig |-> (q.deb_cnt == tgt - DEB_ADD)
			&& (wake_input == q.level);
	endproperty
	a_debounce_len: assert property (p_debounce_len)
		else $error("Wake released before the debounce length");

	property p_alarm_release;
		alarm_evt |=> !power_off_output && q.alarm_flag;
	endproperty
	a_alarm_release: assert property (p_alarm_release)
		else $error("Enabled alarm did not release the output");

	property p_in_flag;
		wake_evt |=> q.in_flag ##1 1'b1;
	endproperty
	a_in_flag: assert property (p_in_flag)
		else $error("Input wake flag not set");

	property p_stat_clear;
		rd_stat && !wake_evt && !alarm_evt |=> !q.in_flag && !q.alarm_flag;
	endproperty
	a_stat_clear: assert property (p_stat_clear)
		else $error("Status flags not cleared by read");

	property p_abort;
		q.armed && (wake_input != q.level) && !trig
			|=> !q.armed && (q.deb_cnt == '0);
	endproperty
	a_abort: assert property (p_abort)
		else $error("Debounce counter not cleared on input change");

	property p_alarm_sync;
		alarm_rise |-> $past(rtc_alarm, 2) && !$past(rtc_alarm, 3);
	endproperty
	a_alarm_sync: assert property (p_alarm_sync)
		else $error("Alarm edge not taken through the synchronizer");

	property p_hold;
		power_off_output && !release_evt |=> power_off_output;
	endproperty
	a_hold: assert property (p_hold)
		else $error("Output dropped without a wake release");

	property p_alarm_gate;
		alarm_rise && !q.cfg_alarm_en && !q.alarm_flag |=> !q.alarm_flag;
	endproperty
	a_alarm_gate: assert property (p_alarm_gate)
		else $error("Disabled alarm set the alarm flag");

	property p_deb_armed;
		wake_evt |-> trig || q.armed;
	endproperty
	a_deb_armed: assert property (p_deb_armed)
		else $error("Wake release without a debounce in progress");

	property p_rd_flag;
		rd_stat |=> hrdata[IN_FLAG_BIT] == $past(q.in_flag);
	endproperty
	a_rd_flag: assert property (p_rd_flag)
		else $error("Status read did not return the input flag");

	property p_idle_rdata;
		!rd_req |=> (hrdata == '0);
	endproperty
	a_idle_rdata: assert property (p_idle_rdata)
		else $error("Read data not zero outside a read");

	property p_irq_level;
		irq == |(q.irq_stat & q.irq_mask);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("Interrupt level differs from masked status");

endmodule : power_down_controller

// ### verification/power_down_controller_tb.sv
// Self-checking bench for the power-down controller
`timescale 1ns/100ps

module power_down_controller_tb;
	import power_down_pkg::*;

	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic wake_input, rtc_alarm, power_off_output, irq, supply_on;
	int fail_count, comparisons, k, cpt, exp_off;

	assign hready = hreadyout;

	power_down_controller u_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wake_input(wake_input), .rtc_alarm(rtc_alarm),
		.power_off_output(power_off_output), .irq(irq));

	wake_source u_far (.hclk(hclk), .power_off_output(power_off_output),
		.wake_input(wake_input), .rtc_alarm(rtc_alarm),
		.supply_on(supply_on));

	initial begin
		hclk = 1'h0;
		forever #12.5 hclk = ~hclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task give_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'($urandom), a};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hsize <= 3'($urandom);
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : ahb

	task shut;
		ahb(1'h1, OFS_CMD, 32'hA500_0001);
		@(posedge hclk);
		#1 check("off early", power_off_output, exp_off);
		@(posedge hclk);
		#1 check("off", power_off_output, 1'h1);
		check("supply off", supply_on, 1'h0);
		exp_off = 1;
	endtask : shut

	// Counts edges from the stimulus edge until the output is released
	task count_off(input string name, input int n);
		k = 0;
		do begin
			@(posedge hclk);
			#1 k++;
		end while (power_off_output !== 1'h0 && k < 400);
		check(name, k, n);
		exp_off = 0;
	endtask : count_off

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		hwrite = 1'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'h0;
		hsize = 3'h2;
		void'($urandom(15005));
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h0, OFS_CFG, 32'h0000_0000);
		check("cfg reset", rd, CFG_RESET);
		ahb(1'h0, OFS_STAT, 32'h0000_0000);
		check("stat reset", rd, 32'h0000_0000);
		ahb(1'h0, 8'h20, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		check("resp", hresp, HRESP_OKAY);
		ahb(1'h1, OFS_CFG, 32'h0000_0000);
		ahb(1'h1, OFS_CMD, {8'($urandom_range(0, 164)), 24'h00_0001});
		ahb(1'h1, OFS_CMD, 32'hFF00_0001);
		ahb(1'h1, OFS_CMD, 32'hA500_0000);
		repeat (3) @(posedge hclk);
		#1 check("bad key", power_off_output, 1'h0);
		shut;
		u_far.set_wake(1'h1);
		repeat (40) @(posedge hclk);
		#1 check("mode none", power_off_output, 1'h1);
		u_far.set_wake(1'h0);
		for (int m = 1; m < 4; m++) begin
			// Zero count on the last mode covers the shortest debounce
			cpt = (m == 3) ? 0 : $urandom_range(1, 3);
			ahb(1'h1, OFS_CFG, 32'h0000_0000);
			u_far.set_wake(m == 2);
			repeat (3) @(posedge hclk);
			ahb(1'h1, OFS_CFG, {24'h00_0000, 4'(cpt), 2'h0, 2'(m)});
			ahb(1'h0, OFS_STAT, 32'h0000_0000);
			shut;
			if (m != 3) begin
				u_far.set_wake(m != 2);
				repeat (4) @(posedge hclk);
				u_far.set_wake(m == 2);
				repeat (80) @(posedge hclk);
				#1 check("glitch", power_off_output, 1'h1);
			end
			u_far.set_wake(m != 2);
			count_off("debounce", cpt * 16 + 1);
			ahb(1'h0, OFS_STAT, 32'h0000_0000);
			check("in flag", rd, 32'h0000_0001);
			ahb(1'h0, OFS_STAT, 32'h0000_0000);
			check("in flag clr", rd, 32'h0000_0000);
		end
		ahb(1'h1, OFS_CFG, 32'h0000_0000);
		shut;
		u_far.set_alarm(1'h1);
		repeat (8) @(posedge hclk);
		u_far.set_alarm(1'h0);
		#1 check("alarm off", power_off_output, 1'h1);
		ahb(1'h0, OFS_STAT, 32'h0000_0000);
		check("no alarm flag", rd, 32'h0000_0000);
		ahb(1'h1, OFS_CFG, 32'h0002_0000);
		u_far.set_alarm(1'h1);
		count_off("alarm", 3);
		u_far.set_alarm(1'h0);
		ahb(1'h0, OFS_STAT, 32'h0000_0000);
		check("alarm flag", rd, 32'h0002_0000);
		ahb(1'h0, OFS_STAT, 32'h0000_0000);
		check("alarm clr", rd, 32'h0000_0000);
		ahb(1'h0, OFS_IRQ_STAT, 32'h0000_0000);
		check("irq stat", rd, 32'h0000_0003);
		check("irq masked", irq, 1'h0);
		ahb(1'h1, OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge hclk);
		#1 check("irq on", irq, 1'h1);
		ahb(1'h1, OFS_IRQ_STAT, 32'h0000_0002);
		repeat (2) @(posedge hclk);
		#1 check("irq clr", irq, 1'h0);
		ahb(1'h0, OFS_IRQ_STAT, 32'h0000_0000);
		check("irq left", rd, 32'h0000_0001);
		give_verdict;
	end

	initial begin
		repeat (30000) @(posedge hclk);
		fail_count++;
		give_verdict;
	end
endmodule : power_down_controller_tb

// ### verification/wake_source.sv
// Far-side model: wake pin source, alarm source and supply converter
`timescale 1ns/100ps

module wake_source (
	input wire logic hclk,
	input wire logic power_off_output,
	output logic wake_input,
	output logic rtc_alarm,
	output logic supply_on
);
	// ------------------------------------------------------------
	// Converter and sources
	// ------------------------------------------------------------
	// Supply follows the shutdown line with no delay of its own
	assign supply_on = !power_off_output;

	initial begin
		wake_input = 1'h0;
		rtc_alarm = 1'h0;
	end

	task set_wake(input logic v);
		@(posedge hclk);
		wake_input <= v;
	endtask : set_wake

	// Alarm is a level from another domain, so callers hold it long
	task set_alarm(input logic v);
		@(posedge hclk);
		rtc_alarm <= v;
	endtask : set_alarm
endmodule : wake_source
